/* File: pkg/scfg_pkg.sv */
// Purpose: Constants for the system configuration model-specific register bank.
// Assumes: Single 125 MHz clock, synchronous active-high reset.
// Notes:   Bit positions follow the register layout; undefined bits stay zero.
package scfg_pkg;
    localparam logic [31:0] SCFG_ADDR        = 32'hC0010010;
    localparam int          SCFG_WIDTH       = 64;
    localparam int          FIX_DRAM_EN_BIT  = 18;
    localparam int          FIX_DRAM_MOD_BIT = 19;
    localparam int          VAR_IO_EN_BIT    = 20;
    localparam int          TOM2_EN_BIT      = 21;
    localparam int          FORCE_WB_BIT     = 22;
    localparam int          MEM_ENC_BIT      = 23;
    localparam logic [63:0] SCFG_DEFINED     = 64'h0000_0000_00FC_0000;
    localparam logic [63:0] SCFG_RESET       = 64'h0000_0000_0000_0000;
    localparam logic [2:0]  MTYPE_WB         = 3'h6;
    localparam logic [7:0]  MTYPE_WB8        = 8'h06;
endpackage : scfg_pkg

/* File: rtl/scfg_wb_select.sv */
// Purpose: Default memory type selection for the upper memory region.
// Assumes: Inputs are steady levels; only force_wb_in comes from the configuration register.
// Notes:   Variable-range and page-table overrides are applied downstream.
`timescale 1ns/100ps
`default_nettype none
module scfg_wb_select
    import scfg_pkg::*;
(
    input  wire logic       force_wb_in,
    input  wire logic       deftype_enable_in,
    input  wire logic [7:0] deftype_type_in,
    input  wire logic       addr_in_upper_in,
    output logic      [7:0] default_type_out,
    output logic            forced_out
);
    wire force_active;
    // Force only applies while default-type enable is set
    assign force_active     = force_wb_in && deftype_enable_in && addr_in_upper_in;
    assign forced_out       = force_active;
    assign default_type_out = force_active ? MTYPE_WB8 : deftype_type_in;
endmodule : scfg_wb_select
`default_nettype wire

/* File: rtl/scfg_bank.sv */
// Purpose: System configuration register with its enable outputs.
// Assumes: Access strobes come from the model-register path; priv_in must be set for an access to hit.
// Notes:   Reads return data one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module scfg_bank
    import scfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        msr_rd_in,
    input  wire logic        msr_wr_in,
    input  wire logic        priv_in,
    input  wire logic [31:0] msr_addr_in,
    input  wire logic [63:0] msr_wdata_in,
    output logic      [63:0] msr_rdata_out,
    output logic             msr_hit_out,
    input  wire logic        system_management_lock_in,
    input  wire logic [1:0]  dram_attr_stored_in,
    output logic      [1:0]  dram_attr_read_out,
    output logic             dram_attr_wr_allow_out,
    output logic             dram_attr_effective_out,
    output logic             variable_range_io_enable_out,
    output logic             second_memory_limit_enable_out,
    output logic             upper_memory_force_writeback_out,
    output logic             memory_encryption_enable_out,
    input  wire logic        deftype_enable_in,
    input  wire logic [7:0]  deftype_type_in,
    input  wire logic        addr_in_upper_in,
    output logic      [7:0]  default_type_out,
    output logic             forced_wb_out
);
    logic [63:0] system_configuration;
    logic [63:0] next_cfg;
    logic [63:0] rdata;
    wire         sel;
    wire         wr_hit;
    wire         rd_hit;
    wire         enc_hold;

    function automatic logic decode(input logic [31:0] a, input logic p);
        decode = p && (a == SCFG_ADDR);
    endfunction : decode

    assign sel     = decode(msr_addr_in, priv_in);
    assign wr_hit  = msr_wr_in && sel;
    assign rd_hit  = msr_rd_in && sel;
    assign msr_hit_out = (msr_rd_in || msr_wr_in) && sel;

    // Lock keeps encryption on once set; undefined bits masked out
    assign enc_hold = system_management_lock_in && system_configuration[MEM_ENC_BIT];
    always_comb begin
        next_cfg = (msr_wdata_in & SCFG_DEFINED);
        if (enc_hold) begin
            next_cfg[MEM_ENC_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            system_configuration <= SCFG_RESET;
        end else if (wr_hit) begin
            system_configuration <= next_cfg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata <= SCFG_RESET;
        end else if (rd_hit) begin
            rdata <= system_configuration & SCFG_DEFINED;
        end
    end
    assign msr_rdata_out = rdata;

    assign dram_attr_wr_allow_out  = system_configuration[FIX_DRAM_MOD_BIT];
    // Attribute reads are masked rather than the stored bits cleared
    assign dram_attr_read_out      = system_configuration[FIX_DRAM_MOD_BIT] ?
                                     dram_attr_stored_in : 2'h0;
    assign dram_attr_effective_out = system_configuration[FIX_DRAM_EN_BIT];
    assign variable_range_io_enable_out     = system_configuration[VAR_IO_EN_BIT];
    assign second_memory_limit_enable_out   = system_configuration[TOM2_EN_BIT];
    assign upper_memory_force_writeback_out = system_configuration[FORCE_WB_BIT];
    assign memory_encryption_enable_out     = system_configuration[MEM_ENC_BIT];

    scfg_wb_select scfg_wb_select_inst (
        .force_wb_in       (system_configuration[FORCE_WB_BIT] &&
                            system_configuration[TOM2_EN_BIT]),
        .deftype_enable_in (deftype_enable_in),
        .deftype_type_in   (deftype_type_in),
        .addr_in_upper_in  (addr_in_upper_in),
        .default_type_out  (default_type_out),
        .forced_out        (forced_wb_out)
    );

    // Storage, lock and reset
    a_lock_sticky: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (system_management_lock_in && memory_encryption_enable_out)
        |=>
        memory_encryption_enable_out
    ) else $error("encryption enable cleared under lock");

    a_enc_set_lock: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_hit && system_management_lock_in && msr_wdata_in[MEM_ENC_BIT])
        |=>
        memory_encryption_enable_out
    ) else $error("encryption enable not set under lock");

    a_enc_write: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_hit && !enc_hold)
        |=>
        memory_encryption_enable_out == $past(msr_wdata_in[MEM_ENC_BIT])
    ) else $error("encryption enable did not follow write");

    a_enc_off: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_hit && !system_management_lock_in && !msr_wdata_in[MEM_ENC_BIT])
        |=>
        !memory_encryption_enable_out
    ) else $error("encryption enable not cleared while unlocked");

    a_write_store: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_hit && !enc_hold)
        |=>
        system_configuration == ($past(msr_wdata_in) & SCFG_DEFINED)
    ) else $error("write not stored");

    a_hold_idle: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !wr_hit
        |=>
        $stable(system_configuration)
    ) else $error("register changed without a write");

    a_undef_zero: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (system_configuration & ~SCFG_DEFINED)
        ==
        64'h0
    ) else $error("undefined bit set");

    a_reset_clear: assert property (
        @(posedge clk_in)
        srst_in
        |=>
        (system_configuration == SCFG_RESET) && (msr_rdata_out == SCFG_RESET)
    ) else $error("reset did not clear register");

    // Enables follow the last accepted write
    a_fix_en: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_hit
        |=>
        dram_attr_effective_out == $past(msr_wdata_in[FIX_DRAM_EN_BIT])
    ) else $error("attribute enable mismatch");

    a_attr_modify: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_hit
        |=>
        dram_attr_wr_allow_out == $past(msr_wdata_in[FIX_DRAM_MOD_BIT])
    ) else $error("attribute write permission mismatch");

    a_attr_mask: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !system_configuration[FIX_DRAM_MOD_BIT]
        |->
        dram_attr_read_out == 2'h0
    ) else $error("attributes visible while blocked");

    a_attr_block: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (wr_hit && !msr_wdata_in[FIX_DRAM_MOD_BIT])
        |=>
        (dram_attr_read_out == 2'h0) && !dram_attr_wr_allow_out
    ) else $error("attribute access left open after clearing");

    a_attr_pass: assert property (
        @(posedge clk_in) disable iff (srst_in)
        dram_attr_wr_allow_out
        |->
        dram_attr_read_out == dram_attr_stored_in
    ) else $error("attributes hidden while allowed");

    a_var_io: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_hit
        |=>
        variable_range_io_enable_out == $past(msr_wdata_in[VAR_IO_EN_BIT])
    ) else $error("I/O range enable did not follow write");

    a_limit2_en: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_hit
        |=>
        second_memory_limit_enable_out == $past(msr_wdata_in[TOM2_EN_BIT])
    ) else $error("second limit enable did not follow write");

    a_force_bit: assert property (
        @(posedge clk_in) disable iff (srst_in)
        wr_hit
        |=>
        upper_memory_force_writeback_out == $past(msr_wdata_in[FORCE_WB_BIT])
    ) else $error("force write-back bit did not follow write");

    // Access decode and read path
    a_addr_decode: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (msr_wr_in && (msr_addr_in != SCFG_ADDR))
        |=>
        $stable(system_configuration)
    ) else $error("write at other address changed register");

    a_priv_only: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !priv_in
        |=>
        $stable(system_configuration)
    ) else $error("unprivileged write");

    a_priv_hit: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !priv_in
        |->
        !msr_hit_out
    ) else $error("hit flagged for unprivileged access");

    a_hit_decode: assert property (
        @(posedge clk_in) disable iff (srst_in)
        msr_hit_out
        ==
        ((msr_rd_in || msr_wr_in) && priv_in && (msr_addr_in == SCFG_ADDR))
    ) else $error("hit flag wrong");

    a_hit_quiet: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !(msr_rd_in || msr_wr_in)
        |->
        !msr_hit_out
    ) else $error("hit flagged without a strobe");

    a_unpriv_read: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (msr_rd_in && !priv_in)
        |=>
        $stable(msr_rdata_out)
    ) else $error("unprivileged read changed read data");

    a_read_data: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (rd_hit && !wr_hit)
        |=>
        msr_rdata_out == $past(system_configuration)
    ) else $error("read data wrong");

    a_read_old: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (rd_hit && wr_hit)
        |=>
        msr_rdata_out == $past(system_configuration)
    ) else $error("read beside a write did not return old value");

    a_rdata_hold: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !rd_hit
        |=>
        $stable(msr_rdata_out)
    ) else $error("read data changed without a read");

    a_rdata_undef: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (msr_rdata_out & ~SCFG_DEFINED)
        ==
        64'h0
    ) else $error("undefined bit read as one");

    // Upper-region default type
    a_force_wb: assert property (
        @(posedge clk_in) disable iff (srst_in)
        forced_wb_out
        |->
        (deftype_enable_in && addr_in_upper_in && (default_type_out == MTYPE_WB8))
    ) else $error("forced write-back without enable");

    a_force_on: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (deftype_enable_in && addr_in_upper_in && upper_memory_force_writeback_out &&
         second_memory_limit_enable_out)
        |->
        (forced_wb_out && (default_type_out == MTYPE_WB8))
    ) else $error("write-back not forced");

    a_no_force_off: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !deftype_enable_in
        |->
        (!forced_wb_out && (default_type_out == deftype_type_in))
    ) else $error("default type replaced while default-type enable clear");

    a_no_force_out: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !addr_in_upper_in
        |->
        (!forced_wb_out && (default_type_out == deftype_type_in))
    ) else $error("default type replaced outside the upper region");

    a_limit2_gate: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !second_memory_limit_enable_out
        |->
        !forced_wb_out
    ) else $error("write-back forced while second limit disabled");

endmodule : scfg_bank
`default_nettype wire

/* File: verif/test_system_config_msr_bank.sv */
// Purpose: Self-checking bench for the system configuration register bank.
// Assumes: Single 125 MHz clock, synchronous active-high reset, strobes one cycle.
// Notes:   Enables are checked after selected writes only, not after each one; reads one cycle after.
`timescale 1ns/100ps
`default_nettype none
module test_system_config_msr_bank;
    import scfg_pkg::*;
    logic clk_in = 1'b0, srst_in = 1'b1, rd = 1'b0, wr = 1'b0, priv = 1'b0, lock = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [63:0] wdata = 64'h0, rdata;
    logic [1:0]  stored = 2'h3, attr_rd;
    logic hit, wr_allow, eff, var_io, tom2, fwb, enc, dt_en = 1'b0, upper = 1'b1, forced;
    logic [7:0]  dt_type = 8'h00, dflt;
    int n_mismatch = 0, n_checks = 0;
    always #4 clk_in = ~clk_in;
    scfg_bank scfg_bank_inst (.clk_in(clk_in), .srst_in(srst_in), .msr_rd_in(rd),
        .msr_wr_in(wr), .priv_in(priv), .msr_addr_in(addr), .msr_wdata_in(wdata),
        .msr_rdata_out(rdata), .msr_hit_out(hit), .system_management_lock_in(lock),
        .dram_attr_stored_in(stored), .dram_attr_read_out(attr_rd),
        .dram_attr_wr_allow_out(wr_allow), .dram_attr_effective_out(eff),
        .variable_range_io_enable_out(var_io), .second_memory_limit_enable_out(tom2),
        .upper_memory_force_writeback_out(fwb), .memory_encryption_enable_out(enc),
        .deftype_enable_in(dt_en), .deftype_type_in(dt_type), .addr_in_upper_in(upper),
        .default_type_out(dflt), .forced_wb_out(forced));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One access cycle; the hit flag is judged while the strobe is up
    task automatic access(input logic w, input logic p, input logic [31:0] a,
                          input logic [63:0] d, input logic exp_hit);
        @(posedge clk_in);
        wr <= w; rd <= ~w; priv <= p; addr <= a; wdata <= d;
        #1 chk({63'h0, hit}, {63'h0, exp_hit});
        @(posedge clk_in);
        wr <= 1'b0; rd <= 1'b0;
        #1;
    endtask : access
    task automatic read_expect(input logic [63:0] exp);
        access(1'b0, 1'b1, SCFG_ADDR, 64'h0, 1'b1);
        chk(rdata, exp);
    endtask : read_expect
    task automatic enables_expect(input logic [5:0] exp);
        chk({58'h0, enc, fwb, tom2, var_io, wr_allow, eff}, {58'h0, exp});
    endtask : enables_expect
    task automatic scn_all_bits;
        chk(rdata, SCFG_RESET);
        enables_expect(6'h00);
        read_expect(SCFG_RESET);
        access(1'b1, 1'b1, SCFG_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
        enables_expect(6'h3F);
        read_expect(SCFG_DEFINED);
        access(1'b1, 1'b0, SCFG_ADDR, 64'h0, 1'b0);
        access(1'b0, 1'b0, SCFG_ADDR, 64'h0, 1'b0);
        access(1'b1, 1'b1, 32'hC0010011, 64'h0, 1'b0);
        access(1'b0, 1'b1, 32'hC0010000, 64'h0, 1'b0);
        chk(rdata, SCFG_DEFINED);
        read_expect(64'h0000_0000_00FC_0000);
        for (int b = 18; b < 24; b++) begin
            access(1'b1, 1'b1, SCFG_ADDR, 64'h1 << b, 1'b1);
            enables_expect(6'h01 << (b - 18));
            read_expect(64'h1 << b);
        end
    endtask : scn_all_bits
    task automatic scn_attr_mask;
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0008_0000, 1'b1);
        chk({62'h0, attr_rd}, 64'h3);
        @(posedge clk_in);
        stored <= 2'h2;
        #1 chk({62'h0, attr_rd}, 64'h2);
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0004_0000, 1'b1);
        chk({62'h0, attr_rd}, 64'h0);
    endtask : scn_attr_mask
    task automatic scn_lock;
        @(posedge clk_in);
        lock <= 1'b1;
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0080_0000, 1'b1);
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0, 1'b1);
        read_expect(64'h0080_0000);
        enables_expect(6'h20);
        @(posedge clk_in);
        lock <= 1'b0;
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0, 1'b1);
        read_expect(64'h0);
        enables_expect(6'h00);
    endtask : scn_lock
    task automatic scn_force_wb;
        @(posedge clk_in);
        dt_en <= 1'b1;
        dt_type <= 8'h01;
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0060_0000, 1'b1);
        chk({55'h0, forced, dflt}, {55'h1, MTYPE_WB8});
        @(posedge clk_in);
        upper <= 1'b0;
        #1 chk({55'h0, forced, dflt}, {56'h0, 8'h01});
        @(posedge clk_in);
        upper <= 1'b1;
        dt_en <= 1'b0;
        #1 chk({55'h0, forced, dflt}, {56'h0, 8'h01});
        @(posedge clk_in);
        dt_en <= 1'b1;
        access(1'b1, 1'b1, SCFG_ADDR, 64'h0040_0000, 1'b1);
        enables_expect(6'h10);
        chk({55'h0, forced, dflt}, {56'h0, 8'h01});
    endtask : scn_force_wb
    // Mid-run reset must clear a fully set register and the read data
    task automatic scn_reset;
        access(1'b1, 1'b1, SCFG_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
        read_expect(SCFG_DEFINED);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        #1 chk(rdata, SCFG_RESET);
        enables_expect(6'h00);
        chk({55'h0, forced, dflt}, {56'h0, 8'h01});
        read_expect(SCFG_RESET);
    endtask : scn_reset
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        scn_all_bits();
        scn_attr_mask();
        scn_lock();
        scn_force_wb();
        scn_reset();
        give_verdict();
    end
endmodule : test_system_config_msr_bank
`default_nettype wire
